// >>> hdl/twwc_pkg.sv
// Shared constants, types and helpers for the two-wire write control link
package twwc_pkg;

    // Frame layout: address bits then data bits, both sent MSB first
    localparam int ADDR_W = 3;
    localparam int DATA_W = 8;
    localparam int FRAME_BITS = ADDR_W + DATA_W;
    // One extra stage catches the clock edge that precedes the stop
    localparam int LINK_W = FRAME_BITS + 1;
    localparam int SEL_W = 1 << ADDR_W;
    localparam int NUM_REGS = 4;

    // Register addresses (indices into the control register array)
    localparam int REG_CTRL = 0;
    localparam int REG_MOD = 1;
    localparam int REG_BIAS = 2;
    localparam int REG_EQ = 3;
    localparam logic [DATA_W-1:0] REG_RESET = 8'h00;

    // Field positions in the control register at address 0
    localparam int BIT_CHIP_ENABLE = 7;
    localparam int BIT_FAULT_DETECT = 3;
    localparam int BIT_MOD_RANGE = 2;
    localparam int BIT_EQ_DISABLE = 1;

    // Edge counter in the system domain
    localparam int CNT_W = 4;
    localparam logic [CNT_W-1:0] RISE_MAX = 4'hf;
    localparam logic [CNT_W-1:0] RISES_NO_STOP_EDGE = 4'hb;
    localparam logic [CNT_W-1:0] RISES_WITH_STOP_EDGE = 4'hc;

    // Host timing, in ns and in system clock cycles (rounded up)
    localparam int CLK_PERIOD_NS = 4;
    localparam int PHASE_NS = 60;
    localparam int DATA_HIGH_NS = 100;
    localparam int PHASE_CYC = (PHASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int GAP_CYC =
        (DATA_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PH_W = 8;

    // Device frame tracker states
    typedef enum logic [1:0] {
        TWWC_FR_IDLE = 2'b01,
        TWWC_FR_BUSY = 2'b10
    } twwc_frame_e;

    // Host sequencer states
    typedef enum logic [8:0] {
        TWWC_H_IDLE = 9'h001,
        TWWC_H_START = 9'h002,
        TWWC_H_LOW_A = 9'h004,
        TWWC_H_LOW_B = 9'h008,
        TWWC_H_HIGH = 9'h010,
        TWWC_H_STOP_A = 9'h020,
        TWWC_H_STOP_B = 9'h040,
        TWWC_H_STOP_C = 9'h080,
        TWWC_H_GAP = 9'h100
    } twwc_host_e;

    // Address to one-hot select lines
    function automatic logic [SEL_W-1:0] twwc_decode(
        input logic [ADDR_W-1:0] addr
    );
        twwc_decode = 8'h01 << addr;
    endfunction

endpackage

// >>> hdl/twwc_link_if.sv
// Two-wire link between host and device, with open-drain resolution
`timescale 1ns/10ps
interface twwc_link_if;
    // Serial clock driver (host side)
    logic sck_out;
    logic sck_oe;
    // Serial data drivers, open drain: only a low is ever driven
    logic sda_host_out;
    logic sda_host_oe;
    logic sda_dev_out;
    logic sda_dev_oe;
    // Resolved line levels, pulled high when nobody pulls low
    wire logic sck;
    wire logic sda;

    assign sck = !(sck_oe && !sck_out);
    assign sda = !((sda_host_oe && !sda_host_out) ||
                   (sda_dev_oe && !sda_dev_out));

    // Controller end
    modport host (
        output sck_out,
        output sck_oe,
        output sda_host_out,
        output sda_host_oe
    );
    // Documented device end
    modport dev (
        input sck,
        input sda,
        output sda_dev_out,
        output sda_dev_oe
    );
endinterface

// >>> hdl/twwc_device.sv
// Device end: serial write port, control registers and modulation gating
`timescale 1ns/10ps
module twwc_device
    import twwc_pkg::*;
(
    // Serial link, clock comes from the controller
    twwc_link_if.dev link,
    // System clock, reset and freeze
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic clk_en,
    // Asynchronous pins
    input wire logic modulation_disable_pin,
    input wire logic fault_pin,
    // Equalizer controls
    output logic equalizer_enable,
    output logic [DATA_W-1:0] equalizer_amount,
    // Modulation generator controls
    output logic [DATA_W-1:0] modulation_code,
    output logic modulation_range_select,
    output logic modulation_enable,
    // Other register contents and status
    output logic [DATA_W-1:0] bias_code,
    output logic [DATA_W-1:0] control_byte,
    output logic fault_latched
);

    // Link-domain state: only the serial shifter
    typedef struct packed {
        logic [LINK_W-1:0] shift;
    } twwc_link_s;

    // System-domain state
    typedef struct packed {
        logic sda_s1;
        logic sda_s2;
        logic sda_p;
        logic sck_s1;
        logic sck_s2;
        logic sck_p;
        logic dis_s1;
        logic dis_s2;
        logic flt_s1;
        logic flt_s2;
        twwc_frame_e state;
        logic [CNT_W-1:0] rises;
        logic [NUM_REGS-1:0][DATA_W-1:0] regs;
        logic fault;
        logic mod_en;
    } twwc_sys_s;

    twwc_link_s lq; // Link-domain registers
    twwc_link_s next_lq; // Link-domain next value
    twwc_sys_s q; // System-domain registers
    twwc_sys_s next_q; // System-domain next value

    logic start_seen; // Start condition on the synchronised lines
    logic stop_seen; // Stop condition on the synchronised lines
    logic clk_rise; // Serial clock rising edge, synchronised
    logic frame_ok; // Frame carried a full word
    logic [FRAME_BITS-1:0] word; // Address and data of the frame
    logic [SEL_W-1:0] sel; // Decoded register selects
    logic fault_now; // Qualified fault this cycle

    // Device is write only and never pulls the data line
    assign link.sda_dev_out = 1'b0;
    assign link.sda_dev_oe = 1'b0;

    // Shifter: every clock rise samples data while the clock is high
    always_comb
    begin
        next_lq = lq;
        next_lq.shift = {lq.shift[LINK_W-2:0], link.sda};
    end

    // Link clock only ticks inside frames, so no other logic lives here
    always_ff @(posedge link.sck or posedge reset)
    begin
        if (reset)
        begin
            lq <= '0;
        end
        else
        begin
            lq <= next_lq;
        end
    end

    // Edge detection on the second synchroniser stage and its delay
    assign start_seen = q.sck_p && q.sck_s2 && q.sda_p && !q.sda_s2;
    assign stop_seen = q.sck_p && q.sck_s2 && !q.sda_p && q.sda_s2;
    assign clk_rise = q.sck_s2 && !q.sck_p;

    // Stop may come with or without one extra clock rise before it
    assign frame_ok = (q.rises == RISES_NO_STOP_EDGE) ||
                      (q.rises == RISES_WITH_STOP_EDGE);
    // The shifter is quiet once the stop is seen, so sampling it is safe
    assign word = (q.rises == RISES_WITH_STOP_EDGE) ?
                  lq.shift[LINK_W-1:1] :
                  lq.shift[FRAME_BITS-1:0];
    assign sel = twwc_decode(word[FRAME_BITS-1:DATA_W]);
    // Fault counts only while detection is switched on
    assign fault_now = q.regs[REG_CTRL][BIT_FAULT_DETECT] && q.flt_s2;

    // Next-state logic of the system domain
    always_comb
    begin
        next_q = q;
        // Two-stage synchronisers, then one delay stage for edges
        next_q.sda_s1 = link.sda;
        next_q.sda_s2 = q.sda_s1;
        next_q.sda_p = q.sda_s2;
        next_q.sck_s1 = link.sck;
        next_q.sck_s2 = q.sck_s1;
        next_q.sck_p = q.sck_s2;
        next_q.dis_s1 = modulation_disable_pin;
        next_q.dis_s2 = q.dis_s1;
        next_q.flt_s1 = fault_pin;
        next_q.flt_s2 = q.flt_s1;
        // Frame tracker
        case (q.state)
            TWWC_FR_IDLE:
            begin
                // Idle until data falls with the clock high
                if (start_seen)
                begin
                    next_q.state = TWWC_FR_BUSY;
                    next_q.rises = '0;
                end
            end
            TWWC_FR_BUSY:
            begin
                if (start_seen)
                begin
                    // Repeated start restarts the count
                    next_q.rises = '0;
                end
                else if (stop_seen)
                begin
                    next_q.state = TWWC_FR_IDLE;
                    // Only addresses below the register count are stored
                    for (int i = 0; i < NUM_REGS; i++)
                    begin
                        if (frame_ok && sel[i])
                        begin
                            next_q.regs[i] = word[DATA_W-1:0];
                        end
                    end
                end
                else if (clk_rise && (q.rises != RISE_MAX))
                begin
                    // Saturate so a runaway frame cannot wrap to valid
                    next_q.rises = q.rises + 1'b1;
                end
            end
            default:
            begin
                next_q.state = TWWC_FR_IDLE;
            end
        endcase
        // Latched fault: a new fault wins over the clear by chip enable low
        next_q.fault = fault_now || (q.fault &&
                       q.regs[REG_CTRL][BIT_CHIP_ENABLE]);
        // Modulation gating, registered so the output is glitch free
        next_q.mod_en = q.regs[REG_CTRL][BIT_CHIP_ENABLE] &&
                        !q.dis_s2 &&
                        !(q.regs[REG_CTRL][BIT_FAULT_DETECT] &&
                          q.fault);
    end

    // System-domain registers; clock enable freezes them all
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            q <= '0;
            // Lines idle high, so syncs start high to avoid false edges
            q.sda_s1 <= 1'b1;
            q.sda_s2 <= 1'b1;
            q.sda_p <= 1'b1;
            q.sck_s1 <= 1'b1;
            q.sck_s2 <= 1'b1;
            q.sck_p <= 1'b1;
            q.state <= TWWC_FR_IDLE;
            q.regs <= {NUM_REGS{REG_RESET}};
        end
        else if (clk_en)
        begin
            q <= next_q;
        end
    end

    // Outputs straight from the control registers, the fault latch and the gating flop
    assign equalizer_enable = !q.regs[REG_CTRL][BIT_EQ_DISABLE];
    assign equalizer_amount = q.regs[REG_EQ];
    assign modulation_code = q.regs[REG_MOD];
    // High selects the wide range, low the narrow one
    assign modulation_range_select =
        q.regs[REG_CTRL][BIT_MOD_RANGE];
    assign modulation_enable = q.mod_en;
    assign bias_code = q.regs[REG_BIAS];
    assign control_byte = q.regs[REG_CTRL];
    assign fault_latched = q.fault;

endmodule

// >>> hdl/twwc_host.sv
// Controller end: turns a write request into one serial frame
`timescale 1ns/10ps
module twwc_host
    import twwc_pkg::*;
#(
    parameter int PHASE_CYCLES = PHASE_CYC, // Cycles per phase, a third of a clock period
    parameter int GAP_CYCLES = GAP_CYC // Data high time after a stop
)
(
    // Serial link, this end makes the clock
    twwc_link_if.host link,
    // System clock, reset and freeze
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic clk_en,
    // Write request
    input wire logic req_valid,
    input wire logic [ADDR_W-1:0] req_addr,
    input wire logic [DATA_W-1:0] req_data,
    output logic req_ready,
    // Status
    output logic busy
);

    // Whole host state
    typedef struct packed {
        twwc_host_e state;
        logic [PH_W-1:0] cnt;
        logic [FRAME_BITS-1:0] bits;
        logic [CNT_W-1:0] nbit;
        logic sck;
        logic sda_low;
    } twwc_host_s;

    twwc_host_s q; // Registered state
    twwc_host_s next_q; // Next state
    logic phase_end; // Last cycle of the current phase

    // The gap phase is longer to honour the data high time
    assign phase_end = (q.state == TWWC_H_GAP) ?
                       (q.cnt == PH_W'(GAP_CYCLES - 1)) :
                       (q.cnt == PH_W'(PHASE_CYCLES - 1));

    // Sequencer: one phase per state, lines change only at phase edges, except the data fall on a request in idle
    always_comb
    begin
        next_q = q;
        next_q.cnt = phase_end ? '0 : q.cnt + 1'b1;
        case (q.state)
            TWWC_H_IDLE:
            begin
                // Both lines rest high between frames
                next_q.cnt = '0;
                next_q.sck = 1'b1;
                next_q.sda_low = 1'b0;
                if (req_valid)
                begin
                    // Start: data falls while the clock stays high
                    next_q.sda_low = 1'b1;
                    next_q.bits = {req_addr, req_data};
                    next_q.nbit = '0;
                    next_q.state = TWWC_H_START;
                end
            end
            TWWC_H_START:
            begin
                if (phase_end)
                begin
                    next_q.sck = 1'b0;
                    next_q.state = TWWC_H_LOW_A;
                end
            end
            TWWC_H_LOW_A:
            begin
                // Hold old data a while after the clock falls
                if (phase_end)
                begin
                    next_q.sda_low = !q.bits[FRAME_BITS-1];
                    next_q.state = TWWC_H_LOW_B;
                end
            end
            TWWC_H_LOW_B:
            begin
                if (phase_end)
                begin
                    next_q.sck = 1'b1;
                    next_q.state = TWWC_H_HIGH;
                end
            end
            TWWC_H_HIGH:
            begin
                if (phase_end)
                begin
                    next_q.sck = 1'b0;
                    next_q.bits = {q.bits[FRAME_BITS-2:0], 1'b0};
                    next_q.nbit = q.nbit + 1'b1;
                    if (q.nbit == CNT_W'(FRAME_BITS - 1))
                    begin
                        next_q.state = TWWC_H_STOP_A;
                    end
                    else
                    begin
                        next_q.state = TWWC_H_LOW_A;
                    end
                end
            end
            TWWC_H_STOP_A:
            begin
                if (phase_end)
                begin
                    next_q.sda_low = 1'b1;
                    next_q.state = TWWC_H_STOP_B;
                end
            end
            TWWC_H_STOP_B:
            begin
                if (phase_end)
                begin
                    next_q.sck = 1'b1;
                    next_q.state = TWWC_H_STOP_C;
                end
            end
            TWWC_H_STOP_C:
            begin
                // Stop: data rises after the clock is already high
                if (phase_end)
                begin
                    next_q.sda_low = 1'b0;
                    next_q.state = TWWC_H_GAP;
                end
            end
            TWWC_H_GAP:
            begin
                if (phase_end)
                begin
                    next_q.state = TWWC_H_IDLE;
                end
            end
            default:
            begin
                next_q.state = TWWC_H_IDLE;
            end
        endcase
    end

    // State register; clock enable freezes everything, the link too
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            q <= '0;
            q.state <= TWWC_H_IDLE;
            q.sck <= 1'b1;
        end
        else if (clk_en)
        begin
            q <= next_q;
        end
    end

    // Clock driven both ways; data only ever pulled low
    assign link.sck_out = q.sck;
    assign link.sck_oe = 1'b1;
    assign link.sda_host_out = 1'b0;
    assign link.sda_host_oe = q.sda_low;
    assign req_ready = (q.state == TWWC_H_IDLE);
    assign busy = (q.state != TWWC_H_IDLE);

endmodule

// >>> verification/twwc_link_checker.sv
// Concurrent checks on the two-wire link between host and device
`timescale 1ns/10ps
module twwc_link_checker (
    // System clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // Host drivers
    input wire logic sck_out,
    input wire logic sck_oe,
    input wire logic sda_host_out,
    input wire logic sda_host_oe,
    // Device drivers
    input wire logic sda_dev_out,
    input wire logic sda_dev_oe,
    // Resolved wires
    input wire logic sck,
    input wire logic sda
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (reset);

    logic sck_q; // Clock level one cycle ago
    logic sda_q; // Data level one cycle ago
    logic [3:0] rises; // Clock rises since the last start

    // Line history; idle high in reset so no false start
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            sck_q <= 1'b1;
            sda_q <= 1'b1;
            rises <= 4'h0;
        end
        else
        begin
            sck_q <= sck;
            sda_q <= sda;
            if (sda_q && !sda && sck)
                rises <= 4'h0;
            else if (!sck_q && sck)
                rises <= rises + 4'h1;
        end
    end

    // Start and stop as seen on the wires
    wire start_seen = sda_q && !sda && sck;
    wire stop_seen = !sda_q && sda && sck;

    chk_dev_silent: assert property (!sda_dev_oe && !sda_dev_out)
        else $error("device drove the data line");
    chk_open_drain: assert property (sda_host_oe |-> !sda_host_out)
        else $error("host drove data high");
    chk_clock_driven: assert property (sck_oe && sck == sck_out)
        else $error("host released the clock");
    chk_start_hold: assert property (start_seen |->
        sck[*3] ##[1:20] !sck)
        else $error("clock did not fall after start");
    chk_bit_stable: assert property ($rose(sck) |-> $stable(sda)[*3])
        else $error("data moved while clock high");
    chk_clock_high: assert property ($rose(sck) |->
        sck[*8] ##1 sck[*5])
        else $error("clock high time too short");
    chk_stop_setup: assert property (stop_seen |-> $past(sck, 3))
        else $error("stop came too soon after clock rise");
    chk_frame_count: assert property (stop_seen |-> rises == 4'hc)
        else $error("wrong number of clock rises in frame");
    chk_idle_after: assert property (stop_seen |->
        (sck && sda)[*8] ##1 (sck && sda)[*8] ##1 (sck && sda)[*7])
        else $error("lines left idle too early");

    // Main events
    cov_start: cover property (start_seen);
    cov_stop: cover property (stop_seen && rises == 4'hc);
    cov_rise: cover property ($rose(sck));
endmodule

// >>> verification/testbench.sv
// Bench: host and device joined, plus a bench-driven second link
`timescale 1ns/10ps
`define CHECK(g, e) \
    begin \
        n_compared++; \
        if ((g) !== (e)) \
        begin \
            num_errors++; \
            $display("BAD %0t mismatch: %h not %h", $time, g, e); \
        end \
    end
module testbench;
    import twwc_pkg::*;
    // Clock, reset and counters
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    int num_errors = 0;
    int n_compared = 0;
    int cycles = 0;
    // Host request side
    logic run = 1'b1;
    logic req_valid = 1'b0;
    logic [2:0] req_addr = 3'h0;
    logic [7:0] req_data = 8'h00;
    logic req_ready;
    logic busy;
    // Pins
    logic dis_pin = 1'b0;
    logic fault_pin = 1'b0;
    // Device outputs
    logic eq_en;
    logic mod_range;
    logic mod_en;
    logic flt;
    logic [7:0] eq_amt;
    logic [7:0] mod_code;
    logic [7:0] bias;
    logic [7:0] ctrl;
    logic [7:0] eq_amt_b;
    // Last twelve bits seen on the wire and their count
    logic [11:0] wire_bits = 12'h000;
    int wire_rises = 0;

    twwc_link_if link ();
    twwc_link_if link_b ();

    always #2 clk_sys = ~clk_sys;

    twwc_host i_twwc_host (.link(link), .clk_sys(clk_sys), .reset(reset),
        .clk_en(run), .req_valid(req_valid), .req_addr(req_addr),
        .req_data(req_data), .req_ready(req_ready), .busy(busy));
    twwc_device i_twwc_device (.link(link), .clk_sys(clk_sys),
        .reset(reset), .clk_en(run), .modulation_disable_pin(dis_pin),
        .fault_pin(fault_pin), .equalizer_enable(eq_en),
        .equalizer_amount(eq_amt), .modulation_code(mod_code),
        .modulation_range_select(mod_range), .modulation_enable(mod_en),
        .bias_code(bias), .control_byte(ctrl), .fault_latched(flt));
    // Second device, its link driven by the bench to break framing
    twwc_device i_twwc_device_b (.link(link_b), .clk_sys(clk_sys),
        .reset(reset), .clk_en(run), .modulation_disable_pin(dis_pin),
        .fault_pin(fault_pin), .equalizer_enable(),
        .equalizer_amount(eq_amt_b), .modulation_code(),
        .modulation_range_select(), .modulation_enable(), .bias_code(),
        .control_byte(), .fault_latched());
    twwc_link_checker i_twwc_link_checker (.clk_sys(clk_sys),
        .reset(reset),
        .sck_out(link.sck_out), .sck_oe(link.sck_oe),
        .sda_host_out(link.sda_host_out), .sda_host_oe(link.sda_host_oe),
        .sda_dev_out(link.sda_dev_out), .sda_dev_oe(link.sda_dev_oe),
        .sck(link.sck), .sda(link.sda));

    // Wire monitor: a start clears the count, each rise shifts a bit
    always @(negedge link.sda)
        if (link.sck === 1'b1)
            wire_rises = 0;
    always @(posedge link.sck)
    begin
        wire_bits = {wire_bits[10:0], link.sda};
        wire_rises++;
    end

    // Hang guard, well above the expected run length
    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 40000)
        begin
            num_errors++;
            $display("BAD %0t timeout", $time);
            end_of_test;
        end
    end

    task automatic end_of_test;
        $display("errors %0d compared %0d", num_errors, n_compared);
        if (num_errors == 0 && n_compared > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // One write through the host, then the wire image is judged
    task automatic host_write(input logic [2:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk_sys);
        req_valid <= 1'b1;
        req_addr <= a;
        req_data <= d;
        @(posedge clk_sys);
        while (req_ready !== 1'b1 && n < 800)
        begin
            @(posedge clk_sys);
            n++;
        end
        req_valid <= 1'b0;
        @(posedge clk_sys);
        while (busy !== 1'b0 && n < 1600)
        begin
            @(posedge clk_sys);
            n++;
        end
        `CHECK(busy, 1'b0)
        `CHECK(req_ready, 1'b1)
        `CHECK(wire_bits, {a, d, 1'b0})
        `CHECK(wire_rises, 12)
        `CHECK({link.sck, link.sda}, 2'b11)
        repeat (4) @(posedge clk_sys);
    endtask

    // Bench link step; delays keep it off the system clock grid
    task automatic raw_step(input logic c, input logic d, input int t);
        link_b.sck_out = c;
        link_b.sda_host_oe = !d;
        #t;
    endtask

    // Start, the n leading bits at a 160 ns period, then stop
    task automatic raw_frame(input logic [10:0] bits, input int n);
        raw_step(1'b1, 1'b1, 41);
        raw_step(1'b1, 1'b0, 40);
        // Clock falls first, so the first bit never moves with it
        raw_step(1'b0, 1'b0, 40);
        for (int i = 10; i > 10 - n; i--)
        begin
            raw_step(1'b0, bits[i], 40);
            raw_step(1'b1, bits[i], 80);
            raw_step(1'b0, bits[i], 40);
        end
        raw_step(1'b0, 1'b0, 40);
        raw_step(1'b1, 1'b0, 40);
        raw_step(1'b1, 1'b1, 400);
    endtask

    task automatic t_reset_values;
        `CHECK(eq_en, 1'b1)
        `CHECK({eq_amt, mod_code, bias, ctrl}, 32'h00000000)
        `CHECK({mod_range, mod_en, flt}, 3'b000)
    endtask

    task automatic t_registers;
        host_write(3'h1, 8'h81);
        host_write(3'h2, 8'h5a);
        host_write(3'h3, 8'hc3);
        host_write(3'h0, 8'h06);
        `CHECK(mod_code, 8'h81)
        `CHECK(bias, 8'h5a)
        `CHECK(eq_amt, 8'hc3)
        `CHECK(ctrl, 8'h06)
        `CHECK({eq_en, mod_range}, 2'b01)
        host_write(3'h0, 8'h00);
        `CHECK({eq_en, mod_range}, 2'b10)
    endtask

    // Writes to the four empty addresses must land nowhere
    task automatic t_unmapped;
        for (int a = 4; a < 8; a++)
            host_write(3'(a), 8'hff);
        `CHECK({ctrl, mod_code, bias, eq_amt}, 32'h00815ac3)
        `CHECK(eq_en, 1'b1)
    endtask

    // Pin and fault gating of the modulation enable
    task automatic t_gating;
        host_write(3'h0, 8'h80);
        `CHECK(mod_en, 1'b1)
        dis_pin <= 1'b1;
        repeat (6) @(posedge clk_sys);
        `CHECK(mod_en, 1'b0)
        dis_pin <= 1'b0;
        fault_pin <= 1'b1;
        repeat (6) @(posedge clk_sys);
        `CHECK({mod_en, flt}, 2'b10)
        host_write(3'h0, 8'h88);
        `CHECK({mod_en, flt}, 2'b01)
        fault_pin <= 1'b0;
        repeat (6) @(posedge clk_sys);
        `CHECK(flt, 1'b1)
        host_write(3'h0, 8'h08);
        `CHECK({mod_en, flt}, 2'b00)
        host_write(3'h0, 8'h88);
        `CHECK({mod_en, flt}, 2'b10)
    endtask

    // Clock enable low freezes the pin path; release lets it through
    task automatic t_freeze;
        run <= 1'b0;
        dis_pin <= 1'b1;
        repeat (6) @(posedge clk_sys);
        `CHECK(mod_en, 1'b1)
        run <= 1'b1;
        repeat (6) @(posedge clk_sys);
        `CHECK(mod_en, 1'b0)
        dis_pin <= 1'b0;
        repeat (6) @(posedge clk_sys);
        `CHECK(mod_en, 1'b1)
    endtask

    // Frames cut short must not write; a whole one must
    task automatic t_short_frame;
        raw_frame({3'h3, 8'ha5}, 6);
        `CHECK(eq_amt_b, 8'h00)
        raw_frame({3'h3, 8'h3c}, 11);
        `CHECK(eq_amt_b, 8'h3c)
        raw_frame({3'h3, 8'hc3}, 9);
        `CHECK(eq_amt_b, 8'h3c)
    endtask

    // Main sequence, with a second reset after the last test
    initial
    begin
        link_b.sck_out = 1'b1;
        link_b.sck_oe = 1'b1;
        link_b.sda_host_out = 1'b0;
        link_b.sda_host_oe = 1'b0;
        repeat (20) @(posedge clk_sys);
        reset <= 1'b0;
        repeat (2) @(posedge clk_sys);
        t_reset_values;
        t_registers;
        t_unmapped;
        t_gating;
        t_freeze;
        t_short_frame;
        @(posedge clk_sys);
        reset <= 1'b1;
        repeat (3) @(posedge clk_sys);
        reset <= 1'b0;
        repeat (2) @(posedge clk_sys);
        t_reset_values;
        end_of_test;
    end
endmodule
